/* core/rcd_conv.sv */
// one converter channel: value storage, enable and selection
`timescale 1ns/1ps
`default_nettype none
module rcd_conv (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      clear_i,
  input  wire logic                      wr_data_i,
  input  wire logic                      wr_servo_i,
  input  wire logic                      wr_en_i,
  input  wire logic [rcd_pkg::CODE_W-1:0] wdata_i,
  input  wire logic                      en_val_i,
  input  wire logic                      servo_gate_i,
  output logic                           enabled_o,
  output logic      [rcd_pkg::CODE_W-1:0] sel_code_o
);
  typedef struct packed {
    logic [rcd_pkg::CODE_W-1:0] data_val;
    logic [rcd_pkg::CODE_W-1:0] servo_val;
    logic                       en;
  } rcd_conv_s;

  rcd_conv_s st;
  rcd_conv_s next_st;

  always_comb begin
    next_st = st;
    if (clear_i) begin
      next_st.data_val  = rcd_pkg::CODE_RESET; // see RULE4
      next_st.servo_val = rcd_pkg::CODE_RESET;
      next_st.en        = 1'b0;
    end else begin
      if (wr_data_i) begin
        next_st.data_val = wdata_i; // see RULE1
      end
      if (wr_servo_i) begin
        next_st.servo_val = wdata_i; // see RULE1
      end
      if (wr_en_i) begin
        next_st.en = en_val_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign enabled_o  = st.en;
  assign sel_code_o = servo_gate_i ? st.servo_val : st.data_val; // see RULE2
endmodule : rcd_conv
`default_nettype wire

/* core/rcd_pkg.sv */
// constants and types for the read channel converter control block
// What this block does
// RULE1: each converter keeps 5-bit data and servo values
// RULE2: servo gate selects servo or data value
// RULE3: disabled converter tristates and powers down (code: shared conv_power_o drops only when all three converters are disabled)
// RULE4: full reset clears all converter registers
// RULE5: partial reset leaves converters untouched
// RULE6: bypass mode pulses fast attack on gate edges
// RULE7: channel off forces cutoff code to eight
// RULE8: channel off forces boost output to ground
// RULE9: channel off forces hysteresis output high
// RULE10: bypass clear, channel off pulls fast attack high
// RULE11: bypass set, channel off steers reference current
// RULE12: boost codes zero and one clamp ground
// RULE13: boost resets to zero count, disabled
// RULE14: ratio mode clear uses level as reference
// RULE15: hysteresis has data and servo registers
// RULE16: forcing never alters stored values
package rcd_pkg;
  localparam int unsigned CODE_W      = 5;
  localparam int unsigned NUM_CONV    = 3;
  localparam int unsigned IDX_CUTOFF  = 0;
  localparam int unsigned IDX_BOOST   = 1;
  localparam int unsigned IDX_HYST    = 2;
  localparam logic [4:0]  CODE_RESET  = 5'h00;
  localparam logic [4:0]  CUTOFF_FORCE = 5'h08;
  localparam logic [4:0]  BOOST_NOBOOST_MAX = 5'h01;
  localparam logic [4:0]  CODE_ZERO   = 5'h00;
  localparam logic [4:0]  CODE_FULL   = 5'h1f;
  // converter output stage selection
  typedef enum logic [1:0] {
    RCD_OUT_CODE,
    RCD_OUT_GROUND,
    RCD_OUT_HIGH
  } rcd_out_e;
endpackage : rcd_pkg

/* core/rcd_top.sv */
// top of the read channel converter control block
`timescale 1ns/1ps
`default_nettype none
module rcd_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       full_reset_powerdown_i,
  input  wire logic                       partial_reset_powerdown_i,
  input  wire logic [2:0]                 wr_data_i,
  input  wire logic [2:0]                 wr_servo_i,
  input  wire logic [2:0]                 wr_enable_i,
  input  wire logic [rcd_pkg::CODE_W-1:0] wdata_i,
  input  wire logic                       converter_enable_bit_i,
  input  wire logic                       wr_mode_i,
  input  wire logic                       bypass_cap_mode_i,
  input  wire logic                       hysteresis_ratio_mode_i,
  input  wire logic                       servo_gate_i,
  input  wire logic                       channel_power_enable_i,
  output logic      [rcd_pkg::CODE_W-1:0] cutoff_code_o,
  output logic                            cutoff_oe_o,
  output logic      [rcd_pkg::CODE_W-1:0] boost_code_o,
  output rcd_pkg::rcd_out_e               boost_mode_o,
  output logic                            boost_oe_o,
  output logic      [rcd_pkg::CODE_W-1:0] hyst_code_o,
  output rcd_pkg::rcd_out_e               hyst_mode_o,
  output logic                            hyst_oe_o,
  output logic                            hyst_level_ref_o,
  output logic                            conv_power_o,
  output logic                            fast_attack_pin_o,
  output logic                            fast_attack_oe_o,
  output logic                            current_reference_input_source_on_o
);
  typedef struct packed {
    logic                       bypass_mode;
    logic                       ratio_mode;
    logic                       gate_q;
    logic                       gate_edge;
    logic [rcd_pkg::CODE_W-1:0] cut_code;
    logic                       cut_oe;
    logic [rcd_pkg::CODE_W-1:0] bst_code;
    rcd_pkg::rcd_out_e          bst_mode;
    logic                       bst_oe;
    logic [rcd_pkg::CODE_W-1:0] hys_code;
    rcd_pkg::rcd_out_e          hys_mode;
    logic                       hys_oe;
    logic [2:0]                 pwr;
  } rcd_top_s;

  rcd_top_s st;
  rcd_top_s next_st;

  logic [2:0]                 conv_en;
  logic [rcd_pkg::CODE_W-1:0] conv_code [rcd_pkg::NUM_CONV];

  // partial reset is deliberately not wired in here
  genvar gi;
  generate
    for (gi = 0; gi < rcd_pkg::NUM_CONV; gi++) begin : g_conv
      rcd_conv u_conv (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .clear_i      (full_reset_powerdown_i), // see RULE4 see RULE5
        .wr_data_i    (wr_data_i[gi]),
        .wr_servo_i   (wr_servo_i[gi]), // see RULE15
        .wr_en_i      (wr_enable_i[gi]),
        .wdata_i      (wdata_i),
        .en_val_i     (converter_enable_bit_i),
        .servo_gate_i (servo_gate_i),
        .enabled_o    (conv_en[gi]),
        .sel_code_o   (conv_code[gi])
      );
    end
  endgenerate

  logic unused_partial;
  assign unused_partial = partial_reset_powerdown_i;

  always_comb begin
    next_st = st;
    if (full_reset_powerdown_i) begin
      next_st.bypass_mode = 1'b0;
      next_st.ratio_mode  = 1'b0;
    end else if (wr_mode_i) begin
      next_st.bypass_mode = bypass_cap_mode_i;
      next_st.ratio_mode  = hysteresis_ratio_mode_i;
    end
    next_st.gate_q    = servo_gate_i;
    next_st.gate_edge = servo_gate_i ^ st.gate_q; // see RULE6
    next_st.pwr       = conv_en; // see RULE3

    // cutoff converter
    next_st.cut_oe   = conv_en[rcd_pkg::IDX_CUTOFF]; // see RULE3
    next_st.cut_code = conv_code[rcd_pkg::IDX_CUTOFF];
    if (!channel_power_enable_i) begin
      next_st.cut_code = rcd_pkg::CUTOFF_FORCE; // see RULE7 see RULE16
    end

    // boost converter
    next_st.bst_oe   = conv_en[rcd_pkg::IDX_BOOST];
    next_st.bst_code = conv_code[rcd_pkg::IDX_BOOST];
    next_st.bst_mode = rcd_pkg::RCD_OUT_CODE;
    if (!channel_power_enable_i) begin
      next_st.bst_mode = rcd_pkg::RCD_OUT_GROUND; // see RULE8
      next_st.bst_code = rcd_pkg::CODE_ZERO;
    end else if (conv_code[rcd_pkg::IDX_BOOST] <=
                 rcd_pkg::BOOST_NOBOOST_MAX) begin
      next_st.bst_mode = rcd_pkg::RCD_OUT_GROUND; // see RULE12 see RULE13
      next_st.bst_code = rcd_pkg::CODE_ZERO;
    end

    // hysteresis converter
    next_st.hys_oe   = conv_en[rcd_pkg::IDX_HYST];
    next_st.hys_code = conv_code[rcd_pkg::IDX_HYST];
    next_st.hys_mode = rcd_pkg::RCD_OUT_CODE;
    if (!channel_power_enable_i) begin
      next_st.hys_mode = rcd_pkg::RCD_OUT_HIGH; // see RULE9
      next_st.hys_code = rcd_pkg::CODE_FULL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st          <= '0;
      st.bst_mode <= rcd_pkg::RCD_OUT_CODE;
      st.hys_mode <= rcd_pkg::RCD_OUT_CODE;
    end else begin
      st <= next_st;
    end
  end

  assign cutoff_code_o    = st.cut_code;
  assign cutoff_oe_o      = st.cut_oe;
  assign boost_code_o     = st.bst_code;
  assign boost_mode_o     = st.bst_mode;
  assign boost_oe_o       = st.bst_oe;
  assign hyst_code_o      = st.hys_code;
  assign hyst_mode_o      = st.hys_mode;
  assign hyst_oe_o        = st.hys_oe;
  assign hyst_level_ref_o = ~st.ratio_mode; // see RULE14
  assign conv_power_o     = |st.pwr;

  // fast attack pin: pulses on gate edges in bypass mode, else holds high while channel off
  always_comb begin
    if (st.bypass_mode) begin
      fast_attack_pin_o = st.gate_edge; // see RULE6
      fast_attack_oe_o  = ~st.gate_edge;
      current_reference_input_source_on_o  = ~channel_power_enable_i; // see RULE11
    end else begin
      fast_attack_pin_o = ~channel_power_enable_i; // see RULE10
      fast_attack_oe_o  = channel_power_enable_i;
      current_reference_input_source_on_o  = 1'b0;
    end
  end
endmodule : rcd_top
`default_nettype wire

/* tb/rcd_asserts.sv */
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module rcd_asserts (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              full_reset_powerdown_i,
  input wire logic              wr_mode_i,
  input wire logic              bypass_cap_mode_i,
  input wire logic              hysteresis_ratio_mode_i,
  input wire logic              servo_gate_i,
  input wire logic              channel_power_enable_i,
  input wire logic [4:0]        cutoff_code_o,
  input wire logic [4:0]        boost_code_o,
  input wire rcd_pkg::rcd_out_e boost_mode_o,
  input wire logic              boost_oe_o,
  input wire rcd_pkg::rcd_out_e hyst_mode_o,
  input wire logic              hyst_level_ref_o,
  input wire logic              conv_power_o,
  input wire logic              fast_attack_pin_o,
  input wire logic              fast_attack_oe_o,
  input wire logic              current_reference_input_source_on_o
);
  logic bypass_capacitor_node;
  logic hr;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the mode bits
  always_ff @(posedge clk_i) begin
    if (rst_i || full_reset_powerdown_i) begin
      {bypass_capacitor_node, hr} <= 2'h0;
    end else if (wr_mode_i) begin
      {bypass_capacitor_node, hr} <= {bypass_cap_mode_i, hysteresis_ratio_mode_i};
    end
  end
  // sampled reset in the antecedent: the edge that releases reset still
  // shows reset values one cycle later
  a_off_cutoff: assert property (
    !rst_i && !channel_power_enable_i |=>
    cutoff_code_o == rcd_pkg::CUTOFF_FORCE) else $error("cutoff not forced");
  a_off_boost: assert property (
    !rst_i && !channel_power_enable_i |=>
    boost_mode_o == rcd_pkg::RCD_OUT_GROUND) else $error("boost not grounded");
  a_off_hyst: assert property (
    !rst_i && !channel_power_enable_i |=>
    hyst_mode_o == rcd_pkg::RCD_OUT_HIGH) else $error("hyst not high");
  a_agc_pull: assert property (!bypass_capacitor_node && !channel_power_enable_i |->
    fast_attack_pin_o && !fast_attack_oe_o) else $error("agc pin not high");
  a_current_reference_input_steer: assert property (bypass_capacitor_node && !channel_power_enable_i [*2]
    |-> current_reference_input_source_on_o) else $error("current_reference_input source off");
  a_gate_pulse: assert property (bypass_capacitor_node && $changed(servo_gate_i) |=>
    fast_attack_pin_o && !fast_attack_oe_o) else $error("no agc pulse");
  a_full_clear: assert property (full_reset_powerdown_i |=> ##1
    !boost_oe_o && !conv_power_o) else $error("full reset left enable");
  a_boost_clamp: assert property (boost_oe_o && boost_mode_o ==
    rcd_pkg::RCD_OUT_CODE |-> boost_code_o > rcd_pkg::BOOST_NOBOOST_MAX)
    else $error("boost clamp missed");
  a_level_ref: assert property (!hr [*3] |-> hyst_level_ref_o)
    else $error("level reference off");
  c_channel_power_enable_back: cover property (!channel_power_enable_i ##1 channel_power_enable_i);
  c_gate_byp: cover property (bypass_capacitor_node && $changed(servo_gate_i));
  c_noboost: cover property (boost_oe_o && boost_mode_o == rcd_pkg::RCD_OUT_GROUND);
endmodule : rcd_asserts
bind rcd_top rcd_asserts rcd_asserts_i (.clk_i, .rst_i, .full_reset_powerdown_i,
  .wr_mode_i, .bypass_cap_mode_i, .hysteresis_ratio_mode_i, .servo_gate_i,
  .channel_power_enable_i, .cutoff_code_o, .boost_code_o, .boost_mode_o,
  .boost_oe_o, .hyst_mode_o, .hyst_level_ref_o, .conv_power_o,
  .fast_attack_pin_o, .fast_attack_oe_o, .current_reference_input_source_on_o);
`default_nettype wire

/* tb/rcd_filter_model.sv */
// external filter as seen from the boost converter
`timescale 1ns/1ps
`default_nettype none
module rcd_filter_model (
  input wire logic              boost_oe_i,
  input wire rcd_pkg::rcd_out_e boost_mode_i,
  output logic                  nominal_boost_o
);
  // grounded boost input means nominal boost
  assign nominal_boost_o = boost_oe_i && boost_mode_i == rcd_pkg::RCD_OUT_GROUND;
endmodule : rcd_filter_model
`default_nettype wire

/* tb/rcd_top_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module rcd_top_test;
  logic clk_i, rst_i, full_reset_powerdown_i, partial_reset_powerdown_i;
  logic [2:0] wr_data_i, wr_servo_i, wr_enable_i;
  logic [4:0] wdata_i, cutoff_code_o, boost_code_o, hyst_code_o;
  logic converter_enable_bit_i, wr_mode_i, bypass_cap_mode_i, nominal;
  logic hysteresis_ratio_mode_i, servo_gate_i, channel_power_enable_i;
  logic cutoff_oe_o, boost_oe_o, hyst_oe_o, hyst_level_ref_o, conv_power_o;
  logic fast_attack_pin_o, fast_attack_oe_o, current_reference_input_source_on_o;
  rcd_pkg::rcd_out_e boost_mode_o, hyst_mode_o;
  int fail_count = 0;
  int n_checks = 0;
  rcd_top rcd_top_i (.*);
  rcd_filter_model rcd_filter_model_i (.boost_oe_i(boost_oe_o),
    .boost_mode_i(boost_mode_o), .nominal_boost_o(nominal));
  always #12.5 clk_i = ~clk_i;
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task chk(input logic [4:0] seen, input logic [4:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // k: 0 data, 1 servo, 2 enable, 3 mode bits
  task wr(input int k, input int i, input logic [4:0] v);
    @(posedge clk_i);
    wdata_i <= v;
    converter_enable_bit_i <= v[0];
    {hysteresis_ratio_mode_i, bypass_cap_mode_i} <= v[2:1];
    wr_data_i[i] <= k == 0;
    wr_servo_i[i] <= k == 1;
    wr_enable_i[i] <= k == 2;
    wr_mode_i <= k == 3;
    @(posedge clk_i);
    {wr_data_i, wr_servo_i, wr_enable_i, wr_mode_i} <= 10'h000;
    tick(2);
  endtask : wr
  task end_of_test;
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    {clk_i, full_reset_powerdown_i, partial_reset_powerdown_i} = 3'h0;
    {wr_data_i, wr_servo_i, wr_enable_i, wr_mode_i, wdata_i} = 15'h0000;
    {converter_enable_bit_i, bypass_cap_mode_i} = 2'h0;
    {hysteresis_ratio_mode_i, servo_gate_i, channel_power_enable_i} = 3'h0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    channel_power_enable_i <= 1'b1;
    tick(3);
    chk(cutoff_oe_o, 5'h00);
    wr(2, 1, 5'h01);
    chk(5'(boost_mode_o), 5'(rcd_pkg::RCD_OUT_GROUND));
    chk(nominal, 1'b1);
    wr(0, 0, 5'h0a);
    wr(1, 0, 5'h15);
    wr(2, 0, 5'h01);
    wr(0, 2, 5'h03);
    wr(1, 2, 5'h1c);
    wr(2, 2, 5'h01);
    chk(cutoff_code_o, 5'h0a);
    chk(hyst_code_o, 5'h03);
    @(posedge clk_i) servo_gate_i <= 1'b1;
    tick(3);
    chk(cutoff_code_o, 5'h15);
    chk(hyst_code_o, 5'h1c);
    @(posedge clk_i) servo_gate_i <= 1'b0;
    tick(3);
    for (int c = 0; c < 4; c++) begin
      wr(0, 1, c[4:0]);
      chk(5'(boost_mode_o), 5'(c < 2 ? rcd_pkg::RCD_OUT_GROUND :
        rcd_pkg::RCD_OUT_CODE));
    end
    @(posedge clk_i) channel_power_enable_i <= 1'b0;
    tick(3);
    chk(cutoff_code_o, 5'h08);
    chk(5'(boost_mode_o), 5'(rcd_pkg::RCD_OUT_GROUND));
    chk(5'(hyst_mode_o), 5'(rcd_pkg::RCD_OUT_HIGH));
    chk({fast_attack_pin_o, fast_attack_oe_o}, 5'h02);
    chk(current_reference_input_source_on_o, 1'b0);
    chk(hyst_code_o, 5'h1f);
    wr(3, 0, 5'h02);
    chk(current_reference_input_source_on_o, 1'b1);
    @(posedge clk_i) channel_power_enable_i <= 1'b1;
    tick(3);
    chk(cutoff_code_o, 5'h0a);
    chk(boost_code_o, 5'h03);
    @(posedge clk_i) servo_gate_i <= 1'b1;
    tick(1);
    chk({fast_attack_pin_o, fast_attack_oe_o}, 5'h02);
    @(posedge clk_i) servo_gate_i <= 1'b0;
    tick(1);
    chk({fast_attack_pin_o, fast_attack_oe_o}, 5'h02);
    tick(1);
    chk({fast_attack_pin_o, fast_attack_oe_o}, 5'h01);
    wr(3, 0, 5'h04);
    chk(hyst_level_ref_o, 1'b0);
    wr(3, 0, 5'h00);
    chk(hyst_level_ref_o, 1'b1);
    @(posedge clk_i) partial_reset_powerdown_i <= 1'b1;
    tick(3);
    chk({cutoff_oe_o, boost_oe_o, hyst_oe_o}, 5'h07);
    chk(cutoff_code_o, 5'h0a);
    chk(conv_power_o, 1'b1);
    @(posedge clk_i) full_reset_powerdown_i <= 1'b1;
    tick(3);
    chk({cutoff_oe_o, boost_oe_o, hyst_oe_o}, 5'h00);
    chk(conv_power_o, 1'b0);
    chk(cutoff_code_o, 5'h00);
    chk(boost_code_o, 5'h00);
    @(posedge clk_i) full_reset_powerdown_i <= 1'b0;
    wr(2, 1, 5'h01);
    chk(boost_oe_o, 1'b1);
    chk(5'(boost_mode_o), 5'(rcd_pkg::RCD_OUT_GROUND));
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
endmodule : rcd_top_test
`default_nettype wire
